//--- access_host.sv
// host side of the timer link: one access command per go pulse
// assumes the block's core_clk and rst_n; go ignored while busy
`timescale 1ns/1ps
module access_host #(
    parameter int BUSY = 3 // command length
) (
    input wire logic core_clk, // clock
    input wire logic rst_n, // reset, low
    input wire logic go, // run one
    output logic access_start, // begin pulse
    output logic access_end // end pulse
);
    int cnt;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt <= 0;
            access_start <= 1'b0;
            access_end <= 1'b0;
        end else begin
            access_start <= go && cnt == 0;
            access_end <= cnt == 1;
            if (go && cnt == 0)
                cnt <= BUSY + 1;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule

//--- mode_pages.sv
// mode page store for caching, capabilities and timer/protect pages,
// register access over AHB-Lite, plus the inactivity standby timer.
// assumes a single slave with zero wait states; access strobes are on core_clk.
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

// Functional notes
// - write cache follows write_cache_on: 0 disables, 1 enables.
// - read-ahead follows read_ahead_off: 0 enables, 1 disables.
// - caching page is code 08h, length 0Ah, and may be saved.
// - caching page changeable mask: byte 2 bits 2 and 0 only.
// - caching defaults: byte 2 = 04h, all else zero.
// - capabilities page is code 1Bh, length 0Ah, save refused.
// - format_progress_flag defaults 1, system_floppy_flag defaults 0.
// - non_cd_optical_flag defaults 1, shared_lun_flag defaults 0.
// - lun_count reports one logical unit.
// - capabilities page has no changeable bits.
// - standby only after the multiplier time from access end; page 1Ch, length 06h.
// - multiplier 0 never, 1-9 from 125 ms doubling, A-F from 1 min.
// - host multiplier 1 to 9 becomes A with a recovered-error report.
// - access_lockout_bit never makes the drive answer not-ready.
// - soft_write_protect_bit never write-protects the media.
// - timer page changeable mask: byte 3 low nibble only.
// - timer defaults: multiplier Fh, protect bits and reserved zero.
// - protect bits are kept among the saved timer values.
// - page_control selects current, changeable, default or saved values.
// - page_savable set only for pages that can be saved.
module mode_pages #(
    parameter int TICK_CYCLES = mode_pages_pkg::TICK_CYCLES_DFLT // cycles per 125 ms tick
) (
    input wire logic core_clk, // 125 MHz clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic hsel, // ahb slave select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size, word only
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic [31:0] hrdata, // ahb read data
    output logic hreadyout, // ahb slave ready
    output logic hresp, // ahb response, always okay
    input wire logic access_start, // pulse: an access command begins
    input wire logic access_end, // pulse: an access command ended
    output logic write_cache_en, // write caching enabled
    output logic read_ahead_en, // read-ahead caching enabled
    output logic standby_req, // drive should enter standby
    output logic not_ready_lock, // lockout of host commands, never set
    output logic media_write_prot // software write protect, never set
);
    import mode_pages_pkg::*;

    typedef enum logic [2:0] {
        TMR_IDLE = 3'b001,
        TMR_COUNT = 3'b010,
        TMR_STANDBY = 3'b100
    } tmr_state_t;

    logic [7:0] sel_code_reg;
    logic [1:0] sel_pc_reg;
    logic [3:0] status_reg;
    logic wce_reg, rcd_reg, access_lockout_bit_reg, soft_write_protect_bit_reg;
    logic [3:0] mult_reg;
    logic sv_wce_reg, sv_rcd_reg, sv_access_lockout_bit_reg, sv_soft_write_protect_bit_reg;
    logic [3:0] sv_mult_reg;
    logic dp_write_reg, dp_valid_reg;
    logic [7:0] dp_addr_reg;
    logic [31:0] hrdata_reg;
    tmr_state_t tmr_state_reg;
    logic [23:0] presc_reg;
    logic [14:0] ticks_reg;

    logic addr_phase;
    logic wr_go;
    logic [3:0] status_set;
    logic [95:0] desc;
    logic page_known;
    logic [14:0] load_ticks;
    logic tick;

    // ticks of 125 ms for each multiplier, zero meaning never
    function automatic logic [14:0] mult_ticks(input logic [3:0] m);
        logic [14:0] t;
        t = 15'd0;
        if (m == 4'h0) begin
            t = 15'd0;
        end else if (m <= MULT_LOW_MAX) begin
            t = 15'd1 << (m - 4'h1);
        end else begin
            t = MIN_TICKS << (m - MULT_SUBST);
        end
        return t;
    endfunction

    // one page descriptor, bytes 0..11 little-endian in 96 bits
    function automatic logic [95:0] build_desc(
        input logic [5:0] code,
        input logic [1:0] pc,
        input logic write_cache_on,
        input logic read_ahead_off,
        input logic [3:0] mult,
        input logic access_lockout_bit,
        input logic soft_write_protect_bit
    );
        logic [95:0] d;
        d = 96'h0;
        case (code)
            CACHE_CODE: begin
                d[7:0] = {1'b1, 1'b0, CACHE_CODE};
                d[15:8] = CACHE_LEN;
                case (pc)
                    PC_CHANGEABLE: d[23:16] = CACHE_B2_MASK;
                    PC_DEFAULT: d[23:16] = CACHE_B2_DFLT;
                    default: d[23:16] = {5'h0, write_cache_on, 1'b0, read_ahead_off};
                endcase
            end
            CAPS_CODE: begin
                d[7:0] = {1'b0, 1'b0, CAPS_CODE};
                d[15:8] = CAPS_LEN;
                if (pc != PC_CHANGEABLE) begin
                    d[23:16] = CAPS_B2_DFLT;
                    d[31:24] = CAPS_B3_DFLT;
                end
                // changeable set stays all zero
            end
            TIMER_CODE: begin
                d[7:0] = {1'b1, 1'b0, TIMER_CODE};
                d[15:8] = TIMER_LEN;
                case (pc)
                    PC_CHANGEABLE: d[31:24] = {4'h0, MULT_MASK};
                    PC_DEFAULT: d[31:24] = {4'h0, MULT_DFLT};
                    default: begin
                        d[31:24] = {4'h0, mult};
                        d[39:32] = {6'h0, access_lockout_bit, soft_write_protect_bit};
                    end
                endcase
            end
            default: d = 96'h0;
        endcase
        return d;
    endfunction

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_go = dp_valid_reg && dp_write_reg;
    assign page_known = (sel_code_reg[5:0] == CACHE_CODE) || (sel_code_reg[5:0] == CAPS_CODE)
        || (sel_code_reg[5:0] == TIMER_CODE);

    // saved set chosen only when page_control asks for it
    always_comb begin
        if (sel_pc_reg == PC_SAVED) begin
            desc = build_desc(sel_code_reg[5:0], sel_pc_reg, sv_wce_reg, sv_rcd_reg,
                sv_mult_reg, sv_access_lockout_bit_reg, sv_soft_write_protect_bit_reg);
        end else begin
            desc = build_desc(sel_code_reg[5:0], sel_pc_reg, wce_reg, rcd_reg,
                mult_reg, access_lockout_bit_reg, soft_write_protect_bit_reg);
        end
    end

    // ahb address phase capture; read data registered for the data phase
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            dp_valid_reg <= addr_phase;
            dp_write_reg <= hwrite;
            dp_addr_reg <= haddr[7:0];
            if (addr_phase && !hwrite) begin
                case (haddr[7:0])
                    PAGE_SEL_OFS: hrdata_reg <= {22'h0, sel_pc_reg, sel_code_reg};
                    STATUS_OFS: hrdata_reg <= {28'h0, status_reg};
                    DESC_W0_OFS: hrdata_reg <= desc[31:0];
                    DESC_W1_OFS: hrdata_reg <= desc[63:32];
                    DESC_W2_OFS: hrdata_reg <= desc[95:64];
                    default: hrdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sel_code_reg <= 8'h00;
            sel_pc_reg <= PC_CURRENT;
        end else if (wr_go && dp_addr_reg == PAGE_SEL_OFS) begin
            sel_code_reg <= hwdata[7:0];
            sel_pc_reg <= hwdata[9:8];
        end
    end

    // current values; fixed bits of any write are dropped
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wce_reg <= CACHE_B2_DFLT[2];
            rcd_reg <= CACHE_B2_DFLT[0];
            mult_reg <= MULT_DFLT;
            access_lockout_bit_reg <= 1'b0;
            soft_write_protect_bit_reg <= 1'b0;
        end else if (wr_go && dp_addr_reg == DESC_W0_OFS) begin
            if (sel_code_reg[5:0] == CACHE_CODE) begin
                wce_reg <= hwdata[WCE_POS];
                rcd_reg <= hwdata[RCD_POS];
            end else if (sel_code_reg[5:0] == TIMER_CODE) begin
                if (hwdata[MULT_POS+3:MULT_POS] != 4'h0
                    && hwdata[MULT_POS+3:MULT_POS] <= MULT_LOW_MAX) begin
                    mult_reg <= MULT_SUBST;
                end else begin
                    mult_reg <= hwdata[MULT_POS+3:MULT_POS];
                end
            end
        end
    end

    // saved set; reset stands in for loading the flash copy
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sv_wce_reg <= CACHE_B2_DFLT[2];
            sv_rcd_reg <= CACHE_B2_DFLT[0];
            sv_mult_reg <= MULT_DFLT;
            sv_access_lockout_bit_reg <= 1'b0;
            sv_soft_write_protect_bit_reg <= 1'b0;
        end else if (wr_go && dp_addr_reg == SAVE_OFS && hwdata[0]) begin
            if (sel_code_reg[5:0] == CACHE_CODE) begin
                sv_wce_reg <= wce_reg;
                sv_rcd_reg <= rcd_reg;
            end else if (sel_code_reg[5:0] == TIMER_CODE) begin
                sv_mult_reg <= mult_reg;
                sv_access_lockout_bit_reg <= access_lockout_bit_reg;
                sv_soft_write_protect_bit_reg <= soft_write_protect_bit_reg;
            end
        end
    end

    // sticky events: a set in the clearing cycle survives
    always_comb begin
        status_set = 4'h0;
        if (wr_go && dp_addr_reg == DESC_W0_OFS && sel_code_reg[5:0] == TIMER_CODE
            && hwdata[MULT_POS+3:MULT_POS] != 4'h0
            && hwdata[MULT_POS+3:MULT_POS] <= MULT_LOW_MAX) begin
            status_set[ST_RECOVERED] = 1'b1;
        end
        if (wr_go && dp_addr_reg == SAVE_OFS && hwdata[0]
            && sel_code_reg[5:0] == CAPS_CODE) begin
            status_set[ST_SAVE_REFUSED] = 1'b1;
        end
        if (wr_go && (dp_addr_reg == SAVE_OFS || dp_addr_reg == DESC_W0_OFS
            || dp_addr_reg == DESC_W1_OFS || dp_addr_reg == DESC_W2_OFS) && !page_known) begin
            status_set[ST_BAD_PAGE] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_reg <= 4'h0;
        end else begin
            status_reg[2:0] <= status_set[2:0] | (status_reg[2:0]
                & ~((wr_go && dp_addr_reg == STATUS_OFS) ? hwdata[2:0] : 3'h0));
            status_reg[ST_STANDBY] <= (tmr_state_reg == TMR_STANDBY);
        end
    end

    // inactivity timer; 125 ms ticks keep the counter narrow
    assign load_ticks = mult_ticks(mult_reg);
    assign tick = (presc_reg == 24'(TICK_CYCLES - 1));

    always_ff @(posedge core_clk) begin
        if (!rst_n || access_end || tmr_state_reg != TMR_COUNT || tick) begin
            presc_reg <= 24'h000000;
        end else begin
            presc_reg <= presc_reg + 24'h000001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tmr_state_reg <= TMR_IDLE;
            ticks_reg <= 15'h0000;
        end else begin
            case (tmr_state_reg)
                TMR_IDLE: begin
                    if (access_end && load_ticks != 15'h0000) begin
                        tmr_state_reg <= TMR_COUNT;
                        ticks_reg <= load_ticks;
                    end
                end
                TMR_COUNT: begin
                    if (access_start || load_ticks == 15'h0000) begin
                        tmr_state_reg <= TMR_IDLE;
                    end else if (access_end) begin
                        ticks_reg <= load_ticks;
                    end else if (tick) begin
                        if (ticks_reg == 15'h0001) begin
                            tmr_state_reg <= TMR_STANDBY;
                        end
                        ticks_reg <= ticks_reg - 15'h0001;
                    end
                end
                TMR_STANDBY: begin
                    if (access_start) begin
                        tmr_state_reg <= TMR_IDLE;
                    end
                end
                default: tmr_state_reg <= TMR_IDLE;
            endcase
        end
    end

    assign standby_req = (tmr_state_reg == TMR_STANDBY);
    assign write_cache_en = wce_reg;
    assign read_ahead_en = !rcd_reg;
    // stored bits are never acted on
    assign not_ready_lock = 1'b0;
    assign media_write_prot = 1'b0;

endmodule

//--- mode_pages_asserts.sv
// port-level checks for the mode page block
// assumes bind onto mode_pages, TICK_CYCLES handed on
`timescale 1ns/1ps
module mode_pages_asserts #(
    parameter int TICK_CYCLES = 4 // cycles per tick
) (
    input wire logic core_clk, // clock
    input wire logic rst_n, // reset, low
    input wire logic hsel, // select
    input wire logic [1:0] htrans, // type
    input wire logic hwrite, // write
    input wire logic access_start, // begin
    input wire logic access_end, // end
    input wire logic write_cache_en, // wr cache
    input wire logic read_ahead_en, // ahead
    input wire logic standby_req, // standby
    input wire logic not_ready_lock, // lock
    input wire logic media_write_prot // protect
);
    // shortest legal wait is multiplier A, 480 ticks
    localparam int MIN_CYC = 480 * TICK_CYCLES - 2;
    int since_end;
    logic wr_take;
    assign wr_take = hsel && htrans[1] && hwrite;
    always_ff @(posedge core_clk) begin
        if (!rst_n || access_start || access_end)
            since_end <= 0;
        else
            since_end <= since_end + 1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    lockout_off_a: assert property (!not_ready_lock)
        else $error("lockout raised");
    wprot_off_a: assert property (!media_write_prot)
        else $error("write protect raised");
    standby_cancel_a: assert property (access_start |=> !standby_req)
        else $error("standby kept past access start");
    standby_hold_a: assert property
        (standby_req && !access_start && !access_end |=> standby_req)
        else $error("standby dropped");
    standby_min_a: assert property ($rose(standby_req) |-> since_end >= MIN_CYC)
        else $error("standby too early");
    wce_cause_a: assert property
        ($changed(write_cache_en) |-> $past(wr_take, 2) || $past(wr_take, 3))
        else $error("write cache changed without write");
    rcd_cause_a: assert property
        ($changed(read_ahead_en) |-> $past(wr_take, 2) || $past(wr_take, 3))
        else $error("read ahead changed without write");
    reset_dflt_a: assert property
        ($rose(rst_n) |-> write_cache_en && read_ahead_en && !standby_req)
        else $error("bad state after reset");
    cover property ($rose(standby_req));
    cover property ($fell(write_cache_en));
    cover property (standby_req && access_start);
endmodule
bind mode_pages mode_pages_asserts #(.TICK_CYCLES(TICK_CYCLES)) mode_pages_asserts_inst (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .access_start(access_start), .access_end(access_end), .write_cache_en(write_cache_en),
    .read_ahead_en(read_ahead_en), .standby_req(standby_req),
    .not_ready_lock(not_ready_lock), .media_write_prot(media_write_prot));

//--- mode_pages_pkg.sv
// constants for the caching, capabilities and timer/protect mode pages
// assumes a 125 MHz core clock and a 32-bit AHB-Lite register bus
package mode_pages_pkg;

    // register byte offsets
    localparam logic [7:0] PAGE_SEL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] SAVE_OFS = 8'h08;
    localparam logic [7:0] DESC_W0_OFS = 8'h10;
    localparam logic [7:0] DESC_W1_OFS = 8'h14;
    localparam logic [7:0] DESC_W2_OFS = 8'h18;

    // page codes and lengths
    localparam logic [5:0] CACHE_CODE = 6'h08;
    localparam logic [7:0] CACHE_LEN = 8'h0A;
    localparam logic [5:0] CAPS_CODE = 6'h1B;
    localparam logic [7:0] CAPS_LEN = 8'h0A;
    localparam logic [5:0] TIMER_CODE = 6'h1C;
    localparam logic [7:0] TIMER_LEN = 8'h06;

    // page control encodings
    localparam logic [1:0] PC_CURRENT = 2'h0;
    localparam logic [1:0] PC_CHANGEABLE = 2'h1;
    localparam logic [1:0] PC_DEFAULT = 2'h2;
    localparam logic [1:0] PC_SAVED = 2'h3;

    // field positions inside the 32-bit descriptor words
    localparam int PS_BIT = 7;
    localparam int WCE_POS = 18;
    localparam int RCD_POS = 16;
    localparam int MULT_POS = 24;

    // defaults and masks
    localparam logic [7:0] CACHE_B2_DFLT = 8'h04;
    localparam logic [7:0] CACHE_B2_MASK = 8'h05;
    localparam logic [7:0] CAPS_B2_DFLT = 8'h40;
    localparam logic [7:0] CAPS_B3_DFLT = 8'h81;
    localparam logic [3:0] MULT_DFLT = 4'hF;
    localparam logic [3:0] MULT_MASK = 4'hF;
    localparam logic [3:0] MULT_SUBST = 4'hA;
    localparam logic [3:0] MULT_LOW_MAX = 4'h9;

    // status register bits
    localparam int ST_RECOVERED = 0;
    localparam int ST_SAVE_REFUSED = 1;
    localparam int ST_BAD_PAGE = 2;
    localparam int ST_STANDBY = 3;

    // inactivity timing
    localparam int CLK_KHZ = 125000;
    localparam int TICK_MS = 125;
    // ms times kHz is already a cycle count: 15,625,000 for one tick
    localparam int TICK_CYCLES_DFLT = TICK_MS * CLK_KHZ;
    localparam logic [14:0] MIN_TICKS = 15'd480;

endpackage

//--- mode_pages_tb_top.sv
// self-checking bench for the mode page block
// assumes mode_pages_pkg, access_host and the checker are compiled
`timescale 1ns/1ps
module mode_pages_tb_top;
    import mode_pages_pkg::*;
    localparam int TICK = 2;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic go = 1'b0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, access_start, access_end;
    logic write_cache_en, read_ahead_en, standby_req, not_ready_lock, media_write_prot;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [5:0] codes [3] = '{CACHE_CODE, CAPS_CODE, TIMER_CODE};
    logic [31:0] dflt [3] = '{32'h00040A88, 32'h81400A1B, 32'h0F00069C};
    logic [31:0] chg [3] = '{32'h00050000, 32'h00000000, 32'h0F000000};
    always #4 core_clk = ~core_clk;
    mode_pages #(.TICK_CYCLES(TICK)) mode_pages_inst (.core_clk(core_clk), .rst_n(rst_n),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .access_start(access_start), .access_end(access_end),
        .write_cache_en(write_cache_en), .read_ahead_en(read_ahead_en),
        .standby_req(standby_req), .not_ready_lock(not_ready_lock),
        .media_write_prot(media_write_prot));
    access_host access_host_inst (.core_clk(core_clk), .rst_n(rst_n), .go(go),
        .access_start(access_start), .access_end(access_end));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // writes get one idle cycle so a following read sees the new value
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        if (w)
            @(posedge core_clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask
    task automatic sel(input logic [5:0] c, input logic [1:0] p);
        bus(PAGE_SEL_OFS, 1'b1, {22'h0, p, 2'h0, c});
    endtask
    task automatic pulse_go;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
    endtask
    task automatic t_pages;
        for (int i = 0; i < 3; i++) begin
            for (int p = 0; p < 4; p++) begin
                sel(codes[i], p[1:0]);
                bus(DESC_W0_OFS, 1'b0, 32'h0);
                if (p == 1)
                    chk(rd & 32'hFFFF0000, chg[i]);
                else
                    chk(rd, dflt[i]);
                rchk(DESC_W1_OFS, 32'h0);
                rchk(DESC_W2_OFS, 32'h0);
            end
        end
        sel(6'h05, PC_CURRENT);
        rchk(DESC_W0_OFS, 32'h0);
        rchk(8'h40, 32'h0);
        bus(SAVE_OFS, 1'b1, 32'h1);
        rchk(STATUS_OFS, 32'h4);
        bus(STATUS_OFS, 1'b1, 32'h4);
        rchk(STATUS_OFS, 32'h0);
        chk(32'(hresp), 32'h0);
        $display("pages done");
    endtask
    task automatic t_cache;
        for (int b = 0; b < 4; b++) begin
            sel(CACHE_CODE, PC_CURRENT);
            bus(DESC_W0_OFS, 1'b1, {8'hFF, 8'hFA | {5'h0, b[1], 1'b0, b[0]}, 16'hFFFF});
            chk(32'(write_cache_en), 32'(b[1]));
            chk(32'(read_ahead_en), 32'(!b[0]));
            rchk(DESC_W0_OFS, {13'h0, b[1], 1'b0, b[0], 16'h0A88});
        end
        sel(CACHE_CODE, PC_DEFAULT);
        rchk(DESC_W0_OFS, 32'h00040A88);
        $display("cache done");
    endtask
    task automatic t_save;
        sel(CACHE_CODE, PC_CURRENT);
        bus(DESC_W0_OFS, 1'b1, 32'h00010000);
        bus(SAVE_OFS, 1'b1, 32'h1);
        bus(DESC_W0_OFS, 1'b1, 32'h00040000);
        sel(CACHE_CODE, PC_SAVED);
        rchk(DESC_W0_OFS, 32'h00010A88);
        rchk(STATUS_OFS, 32'h0);
        sel(CAPS_CODE, PC_CURRENT);
        bus(SAVE_OFS, 1'b1, 32'h1);
        rchk(STATUS_OFS, 32'h2);
        bus(STATUS_OFS, 1'b1, 32'h2);
        rchk(STATUS_OFS, 32'h0);
        $display("save done");
    endtask
    task automatic t_mult;
        sel(TIMER_CODE, PC_CURRENT);
        for (int m = 0; m < 16; m++) begin
            bus(DESC_W0_OFS, 1'b1, {4'hF, m[3:0], 24'hFFFFFF});
            rchk(DESC_W0_OFS, {4'h0, (m >= 1 && m <= 9) ? 4'hA : m[3:0], 24'h00069C});
            rchk(STATUS_OFS, (m >= 1 && m <= 9) ? 32'h1 : 32'h0);
            bus(STATUS_OFS, 1'b1, 32'h1);
        end
        bus(DESC_W1_OFS, 1'b1, 32'h3);
        rchk(DESC_W1_OFS, 32'h0);
        chk(32'({not_ready_lock, media_write_prot}), 32'h0);
        bus(SAVE_OFS, 1'b1, 32'h1);
        bus(DESC_W0_OFS, 1'b1, 32'h0C000000);
        sel(TIMER_CODE, PC_SAVED);
        rchk(DESC_W0_OFS, 32'h0F00069C);
        rchk(DESC_W1_OFS, 32'h0);
        rchk(STATUS_OFS, 32'h0);
        $display("mult done");
    endtask
    task automatic t_standby;
        int n;
        sel(TIMER_CODE, PC_CURRENT);
        for (int k = 0; k < 3; k++) begin
            bus(DESC_W0_OFS, 1'b1, (k == 2) ? 32'h0 : {4'h0, 4'hA + k[3:0], 24'h0});
            pulse_go;
            n = 0;
            while (access_end !== 1'b1 && n < 20) begin
                @(posedge core_clk);
                n++;
            end
            n = 0;
            while (standby_req !== 1'b1 && n < 5000) begin
                @(posedge core_clk);
                n++;
            end
            if (k == 2)
                chk(32'(standby_req), 32'h0);
            else begin
                chk(32'(n >= (480 << k) * TICK - 1 && n <= (480 << k) * TICK + 4), 32'h1);
                rchk(STATUS_OFS, 32'h8);
                pulse_go;
                repeat (2) @(posedge core_clk);
                chk(32'(standby_req), 32'h0);
                repeat (6) @(posedge core_clk);
            end
        end
        $display("standby done");
    endtask
    task automatic end_sim;
        $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_pages;
        t_cache;
        t_save;
        t_mult;
        t_standby;
        end_sim;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        end_sim;
    end
endmodule
